// [ihd_pkg.sv]
// Shared constants and types of the inrush harmonic detector.
package ihd_pkg;

    localparam int            IHD_MAG_W    = 16;
    localparam int            IHD_CNT_W    = 16;
    localparam int            IHD_PCT_W    = 7;
    localparam int            IHD_EV_W     = 5;

    localparam logic [7:0]    OFS_CTRL     = 8'h00;
    localparam logic [7:0]    OFS_RATIO    = 8'h04;
    localparam logic [7:0]    OFS_BASE     = 8'h08;
    localparam logic [7:0]    OFS_NOMINAL  = 8'h0c;
    localparam logic [7:0]    OFS_FLAGS    = 8'h10;
    localparam logic [7:0]    OFS_ISTAT    = 8'h14;
    localparam logic [7:0]    OFS_IEN      = 8'h18;
    localparam logic [7:0]    OFS_ICLR     = 8'h1c;
    localparam logic [7:0]    OFS_COUNT    = 8'h20;

    localparam int            CTRL_OP_BIT  = 0;
    localparam int            FLAGS_ANY    = 3;
    localparam int            FLAGS_BASE_LO = 4;
    localparam int            FLAGS_RAT_LO = 8;
    localparam int            FLAGS_ACT    = 12;
    localparam int            EV_PH_LO     = 0;
    localparam int            EV_ANY       = 3;
    localparam int            EV_BADSET    = 4;

    localparam logic          CTRL_OP_RST  = 1'b1;
    localparam logic [6:0]    RATIO_RST    = 7'h0f;
    localparam logic [6:0]    RATIO_MIN    = 7'h05;
    localparam logic [6:0]    RATIO_MAX    = 7'h32;
    localparam logic [6:0]    BASE_RST     = 7'h1e;
    localparam logic [6:0]    BASE_MIN     = 7'h14;
    localparam logic [6:0]    BASE_MAX     = 7'h64;
    localparam logic [6:0]    PCT_FULL     = 7'h64;
    localparam logic [15:0]   NOMINAL_RST  = 16'h03e8;
    localparam logic [4:0]    IEN_RST      = 5'h00;

    typedef logic [IHD_PCT_W-1:0] ihd_pct_t;
    typedef logic [IHD_EV_W-1:0]  ihd_ev_t;

    typedef enum logic [1:0] {
        IHD_BUS_IDLE,
        IHD_BUS_WRITE,
        IHD_BUS_RD_WAIT,
        IHD_BUS_RD_DONE
    } ihd_bus_t;

endpackage

// [ihd_phase_cmp.sv]
// Per-phase ratio and sensitivity comparison of the inrush detector.
`timescale 1ns/1ps
module ihd_phase_cmp #(
    parameter int MAG_W = ihd_pkg::IHD_MAG_W
) (
    input  wire logic [MAG_W-1:0]      fund,
    input  wire logic [MAG_W-1:0]      harm,
    input  wire logic [MAG_W-1:0]      nominal,
    input  wire ihd_pkg::ihd_pct_t     ratio,
    input  wire ihd_pkg::ihd_pct_t     base,
    output logic                       over_ratio,
    output logic                       above_base,
    output logic                       detect
);
    import ihd_pkg::*;

    localparam int PW = MAG_W + IHD_PCT_W;

    // Compares x*kx against y*ky without any division.
    function automatic logic gt_scaled(
        input logic [MAG_W-1:0] x,
        input ihd_pct_t         kx,
        input logic [MAG_W-1:0] y,
        input ihd_pct_t         ky
    );
        logic [PW-1:0] px;
        logic [PW-1:0] py;
        px = PW'(x) * PW'(kx);
        py = PW'(y) * PW'(ky);
        return px > py;
    endfunction

    always_comb begin
        // Harmonic over fundamental above ratio percent, strictly.
        over_ratio = gt_scaled(harm, PCT_FULL, fund, ratio);
        // Fundamental above base percent of nominal, strictly.
        above_base = gt_scaled(fund, PCT_FULL, nominal, base);
        detect     = over_ratio & above_base;
    end

endmodule

// [ihd_detector.sv]
// Inrush harmonic detector top with its AHB-Lite register slave.
`timescale 1ns/1ps
module ihd_detector #(
    parameter int MAG_W = ihd_pkg::IHD_MAG_W,
    parameter int CNT_W = ihd_pkg::IHD_CNT_W
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    input  wire logic [MAG_W-1:0]  fund_a,
    input  wire logic [MAG_W-1:0]  fund_b,
    input  wire logic [MAG_W-1:0]  fund_c,
    input  wire logic [MAG_W-1:0]  harm_a,
    input  wire logic [MAG_W-1:0]  harm_b,
    input  wire logic [MAG_W-1:0]  harm_c,
    input  wire logic              mag_valid,
    input  wire logic              disable_in,
    output logic                   inrush_a,
    output logic                   inrush_b,
    output logic                   inrush_c,
    output logic                   inrush_any,
    output logic                   irq
);
    import ihd_pkg::*;

    if (MAG_W < 8 || MAG_W > 24) begin : g_bad_mag
        $error("MAG_W must lie between 8 and 24");
    end
    if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt
        $error("CNT_W must lie between 1 and 32");
    end

    typedef struct packed {
        logic              op_on;
        ihd_pct_t          ratio;
        ihd_pct_t          base;
        logic [MAG_W-1:0]  nominal;
        logic [2:0]        flag;
        logic              any;
        logic [2:0]        raw_base;
        logic [2:0]        raw_ratio;
        ihd_ev_t           istat;
        ihd_ev_t           ien;
        logic [CNT_W-1:0]  count;
        ihd_bus_t          bus;
        logic [7:0]        addr;
        logic [31:0]       rdata;
        logic              irq;
    } ihd_state_t;

    localparam ihd_state_t ST_RST = '{
        op_on:     CTRL_OP_RST,
        ratio:     RATIO_RST,
        base:      BASE_RST,
        nominal:   MAG_W'(NOMINAL_RST),
        flag:      3'h0,
        any:       1'b0,
        raw_base:  3'h0,
        raw_ratio: 3'h0,
        istat:     IEN_RST,
        ien:       IEN_RST,
        count:     '0,
        bus:       IHD_BUS_IDLE,
        addr:      8'h00,
        rdata:     32'h0000_0000,
        irq:       1'b0
    };

    ihd_state_t st;
    ihd_state_t next_st;

    logic [2:0][MAG_W-1:0] fund;
    logic [2:0][MAG_W-1:0] harm;
    logic [2:0]            detect;
    logic [2:0]            over_ratio;
    logic [2:0]            above_base;

    assign fund = {fund_c, fund_b, fund_a};
    assign harm = {harm_c, harm_b, harm_a};

    // Every phase has its own comparator and nothing couples them.
    for (genvar p = 0; p < 3; p++) begin : g_phase
        ihd_phase_cmp #(
            .MAG_W (MAG_W)
        ) u_cmp (
            .fund       (fund[p]),
            .harm       (harm[p]),
            .nominal    (st.nominal),
            .ratio      (st.ratio),
            .base       (st.base),
            .over_ratio (over_ratio[p]),
            .above_base (above_base[p]),
            .detect     (detect[p])
        );
    end

    // Ratio and base settings are only accepted inside their documented range.
    function automatic logic in_range(
        input logic [31:0] v,
        input ihd_pct_t    lo,
        input ihd_pct_t    hi
    );
        return v >= 32'(lo) && v <= 32'(hi);
    endfunction

    function automatic logic [31:0] read_reg(
        input ihd_state_t s,
        input logic [7:0] a
    );
        logic [31:0] d;
        d = 32'h0000_0000;
        if (a == OFS_CTRL) begin
            d[CTRL_OP_BIT] = s.op_on;
        end else if (a == OFS_RATIO) begin
            d[IHD_PCT_W-1:0] = s.ratio;
        end else if (a == OFS_BASE) begin
            d[IHD_PCT_W-1:0] = s.base;
        end else if (a == OFS_NOMINAL) begin
            d[MAG_W-1:0] = s.nominal;
        end else if (a == OFS_FLAGS) begin
            d[2:0]                  = s.flag;
            d[FLAGS_ANY]            = s.any;
            d[FLAGS_BASE_LO +: 3]   = s.raw_base;
            d[FLAGS_RAT_LO +: 3]    = s.raw_ratio;
            d[FLAGS_ACT]            = s.op_on & ~disable_in;
        end else if (a == OFS_ISTAT) begin
            d[IHD_EV_W-1:0] = s.istat;
        end else if (a == OFS_IEN) begin
            d[IHD_EV_W-1:0] = s.ien;
        end else if (a == OFS_COUNT) begin
            d[CNT_W-1:0] = s.count;
        end
        return d;
    endfunction

    logic active;
    logic take;

    assign active = st.op_on & ~disable_in;
    assign take   = hsel & hready & htrans[1];

    always_comb begin
        ihd_ev_t    ev;
        ihd_ev_t    clr;
        logic       cnt_clr;
        next_st = st;
        ev      = '0;
        clr     = '0;
        cnt_clr = 1'b0;

        // Flags update on each fresh set of magnitudes while active and clear while inactive.
        if (!active) begin
            next_st.flag = 3'h0;
        end else if (mag_valid) begin
            next_st.flag = detect;
        end
        if (mag_valid) begin
            next_st.raw_base  = above_base;
            next_st.raw_ratio = over_ratio;
        end
        next_st.any = |next_st.flag;

        ev[EV_PH_LO +: 3] = next_st.flag & ~st.flag;
        ev[EV_ANY]        = next_st.any & ~st.any;

        // Write or read data phase of the previous address phase.
        case (st.bus)
            IHD_BUS_WRITE: begin
                if (st.addr == OFS_CTRL) begin
                    next_st.op_on = hwdata[CTRL_OP_BIT];
                end else if (st.addr == OFS_RATIO) begin
                    if (in_range(hwdata, RATIO_MIN, RATIO_MAX)) begin
                        next_st.ratio = hwdata[IHD_PCT_W-1:0];
                    end else begin
                        ev[EV_BADSET] = 1'b1;
                    end
                end else if (st.addr == OFS_BASE) begin
                    if (in_range(hwdata, BASE_MIN, BASE_MAX)) begin
                        next_st.base = hwdata[IHD_PCT_W-1:0];
                    end else begin
                        ev[EV_BADSET] = 1'b1;
                    end
                end else if (st.addr == OFS_NOMINAL) begin
                    next_st.nominal = hwdata[MAG_W-1:0];
                end else if (st.addr == OFS_IEN) begin
                    next_st.ien = hwdata[IHD_EV_W-1:0];
                end else if (st.addr == OFS_ICLR) begin
                    clr = hwdata[IHD_EV_W-1:0];
                end else if (st.addr == OFS_COUNT) begin
                    cnt_clr = 1'b1;
                end
            end
            IHD_BUS_RD_WAIT: begin
                // The one wait state ends here; the data stands in the next cycle.
                next_st.rdata = read_reg(st, st.addr);
                next_st.bus   = IHD_BUS_RD_DONE;
            end
            default: begin
            end
        endcase

        // New address phase, except while a read is still waiting.
        if (st.bus != IHD_BUS_RD_WAIT) begin
            if (take) begin
                next_st.addr = haddr[7:0];
                next_st.bus  = hwrite ? IHD_BUS_WRITE : IHD_BUS_RD_WAIT;
            end else begin
                next_st.bus = IHD_BUS_IDLE;
            end
        end

        // A new event wins over a clear of the same bit.
        next_st.istat = (st.istat & ~clr) | ev;
        if (ev[EV_ANY] && st.count != '1) begin
            next_st.count = st.count + CNT_W'(1);
        end else if (cnt_clr) begin
            next_st.count = '0;
        end
        next_st.irq = |(next_st.istat & next_st.ien);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= ST_RST;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign hreadyout  = st.bus != IHD_BUS_RD_WAIT;
    assign hresp      = 1'b0;
    assign hrdata     = st.rdata;
    assign inrush_a   = st.flag[0];
    assign inrush_b   = st.flag[1];
    assign inrush_c   = st.flag[2];
    assign inrush_any = st.any;
    assign irq        = st.irq;

endmodule

// [ihd_detector_assertions.sv]
// Port-level assertions for the inrush detector.
`timescale 1ns/1ps
module ihd_detector_assertions #(
    parameter int MAG_W = 16
) (
    input wire logic             core_clk,
    input wire logic             rst,
    input wire logic             ce,
    input wire logic             hsel,
    input wire logic [1:0]       htrans,
    input wire logic             hwrite,
    input wire logic             hready,
    input wire logic             hreadyout,
    input wire logic [MAG_W-1:0] fund_a,
    input wire logic [MAG_W-1:0] harm_c,
    input wire logic             mag_valid,
    input wire logic             disable_in,
    input wire logic             inrush_a,
    input wire logic             inrush_b,
    input wire logic             inrush_c,
    input wire logic             inrush_any
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_take;
        ce && hsel && hready && htrans[1];
    endsequence
    sequence s_rd_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    property p_rd; s_take ##0 !hwrite |=> s_rd_wait; endproperty
    property p_wr; s_take ##0 hwrite |=> hreadyout; endproperty
    property p_any; inrush_any == (inrush_a | inrush_b | inrush_c); endproperty
    property p_dis; ce && disable_in |=> !(inrush_a | inrush_b | inrush_c | inrush_any); endproperty
    property p_fund0; ce && mag_valid && fund_a == '0 |=> !inrush_a; endproperty
    property p_harm0; ce && mag_valid && harm_c == '0 |=> !inrush_c; endproperty
    property p_hold; !inrush_b && !(ce && mag_valid) |=> !inrush_b; endproperty
    property p_frz; !ce |=> $stable({inrush_a, inrush_b, inrush_c, hreadyout}); endproperty
    a_rd: assert property (p_rd) else $error("read wait state wrong");
    a_wr: assert property (p_wr) else $error("write stalled");
    a_any: assert property (p_any) else $error("general flag differs from OR");
    a_dis: assert property (p_dis) else $error("flag high while disabled");
    a_fund0: assert property (p_fund0) else $error("flag with zero fundamental");
    a_harm0: assert property (p_harm0) else $error("flag with zero harmonic");
    a_hold: assert property (p_hold) else $error("flag rose without fresh sample");
    a_frz: assert property (p_frz) else $error("state moved while frozen");
endmodule
bind ihd_detector ihd_detector_assertions #(.MAG_W(MAG_W)) i_chk (
    .core_clk(core_clk), .rst(rst), .ce(ce), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .fund_a(fund_a),
    .harm_c(harm_c), .mag_valid(mag_valid), .disable_in(disable_in),
    .inrush_a(inrush_a), .inrush_b(inrush_b), .inrush_c(inrush_c), .inrush_any(inrush_any));

// [ihd_partner.sv]
// Fourier front end and user disable logic that feed the detector.
`timescale 1ns/1ps
module ihd_partner #(
    parameter int W = ihd_pkg::IHD_MAG_W
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic         run,
    input  wire logic [3:0]   gap_max,
    output logic      [W-1:0] fund_a,
    output logic      [W-1:0] fund_b,
    output logic      [W-1:0] fund_c,
    output logic      [W-1:0] harm_a,
    output logic      [W-1:0] harm_b,
    output logic      [W-1:0] harm_c,
    output logic              mag_valid,
    output logic              disable_in
);
    int gap;
    // Fundamentals favour values that sit exactly on the default thresholds.
    function automatic logic [W-1:0] fpick();
        case ($urandom % 4)
            0: return W'(300);
            1: return W'(1000);
            2: return '0;
            default: return W'($urandom % 2000);
        endcase
    endfunction
    function automatic logic [W-1:0] hpick();
        return ($urandom % 2) ? W'(10 * ($urandom % 52)) : W'($urandom % 600);
    endfunction
    // Magnitudes change every cycle, so only sampling on the valid pulse is safe.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            {fund_a, fund_b, fund_c, harm_a, harm_b, harm_c} <= '0;
            mag_valid <= 1'b0;
            disable_in <= 1'b0;
            gap <= 0;
        end else begin
            fund_a <= fpick();
            fund_b <= fpick();
            fund_c <= fpick();
            harm_a <= hpick();
            harm_b <= hpick();
            harm_c <= hpick();
            mag_valid <= run && gap == 0;
            gap <= (gap == 0) ? int'($urandom % (gap_max + 1)) : gap - 1;
            disable_in <= run && $urandom % 16 == 0;
        end
    end
endmodule

// [ihd_detector_tb.sv]
// Self-checking bench for the inrush detector.
`timescale 1ns/1ps
module ihd_detector_tb;
    import ihd_pkg::*;
    logic        core_clk = 0, rst = 1, ce = 1, hsel = 0, hwrite = 0, run = 0;
    logic        hreadyout, mv, dis, ia, ib, ic, iany, irq;
    logic [1:0]  htrans = 0;
    logic [3:0]  gmax = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [15:0] fa, fb, fc, ha, hb, hc, cnt;
    logic [2:0]  f, nf, rb, rr;
    logic [4:0]  ien, ist, ev, clr;
    logic [7:0]  wa, ra;
    int          n_fail = 0, checks_done = 0, op, ratio, base, nom, rph, wph, d;
    logic [31:0] rq[$];
    logic [4:0]  fq[$];
    logic [7:0]  al[10] = '{OFS_CTRL, OFS_RATIO, OFS_BASE, OFS_NOMINAL, OFS_ISTAT,
                            OFS_IEN, OFS_ICLR, OFS_COUNT, OFS_FLAGS, 8'h40};
    int          bv[8] = '{4, 5, 50, 51, 19, 20, 100, 101};
    ihd_detector i_dut (.core_clk(core_clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .fund_a(fa), .fund_b(fb),
        .fund_c(fc), .harm_a(ha), .harm_b(hb), .harm_c(hc), .mag_valid(mv), .disable_in(dis),
        .inrush_a(ia), .inrush_b(ib), .inrush_c(ic), .inrush_any(iany), .irq(irq));
    ihd_partner i_fe (.core_clk(core_clk), .rst(rst), .run(run), .gap_max(gmax),
        .fund_a(fa), .fund_b(fb), .fund_c(fc), .harm_a(ha), .harm_b(hb), .harm_c(hc),
        .mag_valid(mv), .disable_in(dis));
    initial begin
        forever #50 core_clk = ~core_clk;
    end
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wait_rdy();
        int k;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 20);
        if (hreadyout !== 1'b1) n_fail++;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input int v);
        hsel <= 1;
        hwrite <= w;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        wait_rdy();
        hsel <= 0;
        htrans <= 2'b00;
        hwdata <= v;
        wait_rdy();
    endtask
    function automatic logic det(logic [15:0] fu, logic [15:0] hm);
        return (hm * 100 > fu * ratio) && (fu * 100 > nom * base);
    endfunction
    function automatic logic [31:0] rdv(logic [7:0] a);
        case (a)
            OFS_CTRL: return op;
            OFS_RATIO: return ratio;
            OFS_BASE: return base;
            OFS_NOMINAL: return nom;
            OFS_ISTAT: return ist;
            OFS_IEN: return ien;
            OFS_COUNT: return cnt;
            OFS_FLAGS: return {19'h0, op[0] & ~dis, 1'b0, rr, 1'b0, rb, |f, f};
            default: return 0;
        endcase
    endfunction
    // Reference model; a note made at one edge is compared at the next.
    always @(posedge core_clk) begin
        if (rst) begin
            op = 1; ratio = 15; base = 30; nom = 1000; ien = 0; ist = 0; cnt = 0;
            f = 0; wph = 0; rph = 0; fq.delete(); rq.delete();
            rb = 0; rr = 0;
        end else if (ce) begin
            clr = 0;
            if (fq.size() != 0) cmp("flags", 32'(fq.pop_front()), {irq, iany, ic, ib, ia});
            if (rph == 2) cmp("rdata", rq.pop_front(), hrdata);
            if (rph == 1) rq.push_back(rdv(ra));
            rph = (rph == 1) ? 2 : 0;
            nf = (op == 0 || dis) ? 3'h0 : mv ? {det(fc, hc), det(fb, hb), det(fa, ha)} : f;
            // Raw comparison results follow every fresh sample, gated or not.
            if (mv) begin
                rb = {fc * 100 > nom * base, fb * 100 > nom * base, fa * 100 > nom * base};
                rr = {hc * 100 > fc * ratio, hb * 100 > fb * ratio, ha * 100 > fa * ratio};
            end
            ev = {1'b0, (|nf) & ~(|f), nf & ~f};
            if (wph) begin
                d = hwdata;
                case (wa)
                    OFS_CTRL: op = hwdata[0];
                    OFS_RATIO: if (d >= 5 && d <= 50) ratio = d; else ev[4] = 1;
                    OFS_BASE: if (d >= 20 && d <= 100) base = d; else ev[4] = 1;
                    OFS_NOMINAL: nom = hwdata[15:0];
                    OFS_IEN: ien = hwdata[4:0];
                    OFS_ICLR: clr = hwdata[4:0];
                    OFS_COUNT: cnt = 0;
                    default: ;
                endcase
            end
            ist = (ist & ~clr) | ev;
            if (ev[3] && cnt != 16'hffff) cnt++;
            f = nf;
            fq.push_back({|(ist & ien), |nf, nf});
            wph = hsel && hreadyout && htrans[1] && hwrite;
            if (hsel && hreadyout && htrans[1]) begin
                wa = haddr[7:0];
                ra = haddr[7:0];
                rph = !hwrite;
            end
        end
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        results();
    end
    initial begin
        void'($urandom(32'h4351598f));
        repeat (12) @(posedge core_clk);
        rst <= 0;
        @(posedge core_clk);
        foreach (al[i]) bus(0, al[i], 0);
        for (int i = 0; i < 8; i++) begin
            bus(1, i < 4 ? OFS_RATIO : OFS_BASE, bv[i]);
            bus(0, i < 4 ? OFS_RATIO : OFS_BASE, 0);
        end
        bus(0, OFS_ISTAT, 0);
        bus(1, OFS_ICLR, 32'h1f);
        bus(1, OFS_IEN, 32'h1f);
        run <= 1;
        for (int i = 0; i < 400; i++) begin
            gmax <= (i < 200) ? 4'h0 : 4'h7;
            case ($urandom % 8)
                0: bus(1, OFS_RATIO, $urandom % 64);
                1: bus(1, OFS_BASE, $urandom % 128);
                2: bus(1, OFS_CTRL, $urandom % 4 != 0);
                3: bus(1, OFS_NOMINAL, 500 + $urandom % 1000);
                4: bus(1, OFS_ICLR, $urandom % 32);
                5: bus(1, OFS_IEN, $urandom % 32);
                6: bus(0, al[$urandom % 10], 0);
                default: begin
                    ce <= 0;
                    repeat (3) @(posedge core_clk);
                    ce <= 1;
                    @(posedge core_clk);
                end
            endcase
        end
        run <= 0;
        repeat (20) @(posedge core_clk);
        bus(0, OFS_COUNT, 0);
        bus(1, OFS_COUNT, 0);
        bus(0, OFS_COUNT, 0);
        results();
    end
endmodule
